// ---- scp_regs.svh ----
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// Register byte addresses on the AXI4-Lite slave
`define SCP_CTRL1_ADDR 8'h00
`define SCP_CTRL2_ADDR 8'h04
`define SCP_STATUS_ADDR 8'h08

// Control one field positions
`define SCP_C1_PRI_LSB 0
`define SCP_C1_SEC_LSB 2
`define SCP_C1_EDGE_BIT 8
`define SCP_C1_MASTER_BIT 5
`define SCP_C1_MASK 16'h01FF

// Control two field positions
`define SCP_C2_FRM_BIT 15
`define SCP_C2_FSD_BIT 14
`define SCP_C2_FPOL_BIT 13
`define SCP_C2_FEDGE_BIT 1
`define SCP_C2_EBUF_BIT 0
`define SCP_C2_MASK 16'hE003

// Reset values
`define SCP_CTRL1_RST 16'h0000
`define SCP_CTRL2_RST 16'h0000

// Divider figures
`define SCP_SEC_MAX 4'h8
`define SCP_CNT_W 10

// AXI responses
`define SCP_RESP_OKAY 2'b00
`define SCP_RESP_SLVERR 2'b10

`endif

// ---- scp_pkg.sv ----
package scp_pkg;

  typedef enum logic [2:0] {
    SCP_FS_IDLE = 3'b001,
    SCP_FS_LEAD = 3'b010,
    SCP_FS_BIT = 3'b100
  } scp_fs_e;

  typedef struct packed {
    logic framed;
    logic fs_dir_in;
    logic fs_pol_high;
    logic fs_edge_first;
    logic ebuf;
  } scp_frame_cfg_s;

endpackage : scp_pkg

// ---- scp_cfg_if.sv ----
`timescale 1ns/1ns
interface scp_cfg_if;
  logic [1:0] pri_sel;
  logic [2:0] sec_sel;
  logic run;
  logic sclk_en;
  logic sclk_lvl;

  modport ctrl (output pri_sel, output sec_sel, output run, input sclk_en, input sclk_lvl);
  modport div (input pri_sel, input sec_sel, input run, output sclk_en, output sclk_lvl);
endinterface : scp_cfg_if

// ---- scp_sync2.sv ----
`timescale 1ns/1ns
module scp_sync2 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic meta_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule : scp_sync2

// ---- scp_prescaler.sv ----
`timescale 1ns/1ns
`include "scp_regs.svh"
module scp_prescaler (
  input wire logic clk,
  input wire logic rst_b,
  scp_cfg_if.div cfg
);
  // ----------------------------------------
  // Ratio decode
  // ----------------------------------------
  function automatic logic [6:0] pri_ratio(input logic [1:0] sel);
    case (sel)
      2'b11: pri_ratio = 7'h01;
      2'b10: pri_ratio = 7'h04;
      2'b01: pri_ratio = 7'h10;
      default: pri_ratio = 7'h40;
    endcase
  endfunction : pri_ratio

  logic [3:0] sec_ratio;
  logic [6:0] pri_r;
  logic [`SCP_CNT_W-1:0] prod;
  logic [`SCP_CNT_W-1:0] per;
  logic [`SCP_CNT_W-1:0] cnt_ff;
  logic [`SCP_CNT_W-1:0] half;

  assign pri_r = pri_ratio(cfg.pri_sel);
  // Eight minus the code: 111 gives 1, 000 gives 8
  assign sec_ratio = `SCP_SEC_MAX - {1'b0, cfg.sec_sel};
  assign prod = `SCP_CNT_W'(pri_r * sec_ratio);
  // A ratio of one cannot show both phases on a single clock, so it runs at
  // half the clock; bits then advance once per visible period.
  assign per = (prod == `SCP_CNT_W'(1)) ? `SCP_CNT_W'(2) : prod;
  assign half = per >> 1;

  // ----------------------------------------
  // Bit clock: one enable every per cycles (prod, or two when prod is one)
  // ----------------------------------------
  // Preloaded so the first enable lands one full period after run rises
  always_ff @(posedge clk) begin
    if (!rst_b || !cfg.run) begin
      cnt_ff <= `SCP_CNT_W'(1);
    end else if (cnt_ff >= per - 1'b1) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !cfg.run) begin
      cfg.sclk_en <= 1'b0;
      cfg.sclk_lvl <= 1'b0;
    end else begin
      cfg.sclk_en <= (cnt_ff >= per - 1'b1);
      cfg.sclk_lvl <= (cnt_ff < half);
    end
  end
endmodule : scp_prescaler

// ---- scp_port_ctrl.sv ----
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "scp_regs.svh"
// Summary of operation
// - Secondary code 111 divides one, 000 eight
// - Primary codes 11,10,01,00 divide 1,4,16,64
// - Serial clock is instruction clock over product; a product of one gives half the clock
// - Framed enable bit selects framed operation
// - Direction bit: set input, clear output
// - Polarity bit: set active high, clear low
// - Edge bit: coincide with first bit, else before; output sync only, an input sync edge always starts the first bit
// - Enhanced buffer bit selects enhanced buffering
module scp_port_ctrl (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic FRAME_START,
  input wire logic FSYNC_IN,
  output logic FSYNC_OUT,
  output logic FSYNC_OE,
  output logic SCLK_OUT,
  output logic SCLK_OE,
  output logic FRAME_ACTIVE,
  output logic ENH_BUF_MODE
);
  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] ctrl1_ff;
  logic [15:0] ctrl2_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic fs_in_sync;
  logic fs_in_prev_ff;
  logic fs_in_seen_ff;
  logic [3:0] bit_cnt_ff;
  scp_pkg::scp_fs_e fs_state_ff;
  scp_pkg::scp_fs_e nxt_fs_state;
  scp_pkg::scp_frame_cfg_s fcfg;

  scp_cfg_if cfg_if ();

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    merge16 = v & mask;
  endfunction : merge16

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data are caught in either order; the response follows both.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `SCP_RESP_OKAY;
    end else begin
      AWREADY <= !aw_got_ff && !AWREADY && !BVALID;
      WREADY <= !w_got_ff && !WREADY && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got_ff <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      if (aw_got_ff && w_got_ff && !BVALID) begin
        BVALID <= 1'b1;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        if (awaddr_ff == `SCP_CTRL1_ADDR || awaddr_ff == `SCP_CTRL2_ADDR ||
            awaddr_ff == `SCP_STATUS_ADDR) begin
          BRESP <= `SCP_RESP_OKAY;
        end else begin
          BRESP <= `SCP_RESP_SLVERR;
        end
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ctrl1_ff <= `SCP_CTRL1_RST;
      ctrl2_ff <= `SCP_CTRL2_RST;
    end else if (aw_got_ff && w_got_ff && !BVALID) begin
      if (awaddr_ff == `SCP_CTRL1_ADDR) begin
        ctrl1_ff <= merge16(ctrl1_ff, wdata_ff, wstrb_ff, `SCP_C1_MASK);
      end
      if (awaddr_ff == `SCP_CTRL2_ADDR) begin
        // Unimplemented bits 12..2 stay zero
        ctrl2_ff <= merge16(ctrl2_ff, wdata_ff, wstrb_ff, `SCP_C2_MASK);
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= `SCP_RESP_OKAY;
    end else begin
      ARREADY <= !ARREADY && !RVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= `SCP_RESP_OKAY;
        case (ARADDR)
          `SCP_CTRL1_ADDR: RDATA <= {16'h0000, ctrl1_ff};
          `SCP_CTRL2_ADDR: RDATA <= {16'h0000, ctrl2_ff};
          `SCP_STATUS_ADDR: RDATA <= {25'h000_0000, fs_state_ff, bit_cnt_ff};
          default: begin
            RDATA <= 32'h0000_0000;
            RRESP <= `SCP_RESP_SLVERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  assign fcfg.framed = ctrl2_ff[`SCP_C2_FRM_BIT];
  assign fcfg.fs_dir_in = ctrl2_ff[`SCP_C2_FSD_BIT];
  assign fcfg.fs_pol_high = ctrl2_ff[`SCP_C2_FPOL_BIT];
  assign fcfg.fs_edge_first = ctrl2_ff[`SCP_C2_FEDGE_BIT];
  assign fcfg.ebuf = ctrl2_ff[`SCP_C2_EBUF_BIT];

  // The clock runs only in master role while a frame is being timed.
  assign cfg_if.pri_sel = ctrl1_ff[`SCP_C1_PRI_LSB +: 2];
  assign cfg_if.sec_sel = ctrl1_ff[`SCP_C1_SEC_LSB +: 3];
  assign cfg_if.run = ctrl1_ff[`SCP_C1_MASTER_BIT] && (fs_state_ff != scp_pkg::SCP_FS_IDLE);

  scp_prescaler u_pre (
    .clk(CLOCK),
    .rst_b(RST_B),
    .cfg(cfg_if.div)
  );

  scp_sync2 u_fs_sync (
    .clk(CLOCK),
    .rst_b(RST_B),
    .din(FSYNC_IN),
    .dout(fs_in_sync)
  );

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // Edge select in control one is ignored while framed; software keeps it zero.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      fs_in_prev_ff <= 1'b0;
      fs_in_seen_ff <= 1'b0;
    end else begin
      fs_in_prev_ff <= fs_in_sync;
      // Input pulse counts at its active edge per polarity
      fs_in_seen_ff <= fcfg.framed && fcfg.fs_dir_in &&
                       (fcfg.fs_pol_high ? (fs_in_sync && !fs_in_prev_ff)
                                         : (!fs_in_sync && fs_in_prev_ff));
    end
  end

  always_comb begin
    nxt_fs_state = fs_state_ff;
    case (fs_state_ff)
      scp_pkg::SCP_FS_IDLE: begin
        if (fcfg.framed && !fcfg.fs_dir_in && FRAME_START) begin
          nxt_fs_state = fcfg.fs_edge_first ? scp_pkg::SCP_FS_BIT : scp_pkg::SCP_FS_LEAD;
        end else if (fs_in_seen_ff) begin
          nxt_fs_state = scp_pkg::SCP_FS_BIT;
        end
      end
      scp_pkg::SCP_FS_LEAD: begin
        if (cfg_if.sclk_en) nxt_fs_state = scp_pkg::SCP_FS_BIT;
      end
      scp_pkg::SCP_FS_BIT: begin
        if (!fcfg.framed || (cfg_if.sclk_en && bit_cnt_ff == 4'hF)) begin
          nxt_fs_state = scp_pkg::SCP_FS_IDLE;
        end
      end
      default: nxt_fs_state = scp_pkg::SCP_FS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      fs_state_ff <= scp_pkg::SCP_FS_IDLE;
      bit_cnt_ff <= 4'h0;
    end else begin
      fs_state_ff <= nxt_fs_state;
      if (fs_state_ff != scp_pkg::SCP_FS_BIT) begin
        bit_cnt_ff <= 4'h0;
      end else if (cfg_if.sclk_en) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      FSYNC_OUT <= 1'b1;
      FSYNC_OE <= 1'b0;
      SCLK_OUT <= 1'b0;
      SCLK_OE <= 1'b0;
      FRAME_ACTIVE <= 1'b0;
      ENH_BUF_MODE <= 1'b0;
    end else begin
      FSYNC_OE <= fcfg.framed && !fcfg.fs_dir_in;
      // Pulse spans the lead bit, or the first bit when coincident
      FSYNC_OUT <= ((fs_state_ff == scp_pkg::SCP_FS_LEAD) ||
                    (fs_state_ff == scp_pkg::SCP_FS_BIT && bit_cnt_ff == 4'h0 &&
                     fcfg.fs_edge_first)) ~^ fcfg.fs_pol_high;
      SCLK_OUT <= cfg_if.sclk_lvl;
      SCLK_OE <= ctrl1_ff[`SCP_C1_MASTER_BIT];
      FRAME_ACTIVE <= fcfg.framed && (fs_state_ff == scp_pkg::SCP_FS_BIT);
      ENH_BUF_MODE <= fcfg.ebuf;
    end
  end
endmodule : scp_port_ctrl

// ---- scp_port_ctrl_chk.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module scp_port_chk (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic FSYNC_OUT,
  input wire logic FSYNC_OE,
  input wire logic SCLK_OE,
  input wire logic FRAME_ACTIVE,
  input wire logic ENH_BUF_MODE
);
  logic [15:0] c1_ff;
  logic [15:0] c2_ff;
  logic [15:0] hi_ff;
  logic [2:0] q_ff;
  logic [15:0] n_raw;
  logic [15:0] per;
  logic quiet;
  logic wr_go;
  assign wr_go = AWVALID && AWREADY && WVALID && WREADY;
  // Shadow runs ahead of the design, so level checks wait for a quiet bus
  assign quiet = (q_ff == 3'h7) && !BVALID;
  assign n_raw = (16'h0001 << (4'h6 - {1'b0, c1_ff[1:0], 1'b0})) * (16'h0008 - {13'h0000, c1_ff[4:2]});
  assign per = (n_raw == 16'h0001) ? 16'h0002 : n_raw;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      c1_ff <= 16'h0000;
      c2_ff <= 16'h0000;
    end else if (wr_go && AWADDR == 8'h00) begin
      c1_ff <= WDATA[15:0];
    end else if (wr_go && AWADDR == 8'h04) begin
      c2_ff <= WDATA[15:0];
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_B || (AWVALID && AWREADY)) begin
      q_ff <= 3'h0;
    end else if (q_ff != 3'h7) begin
      q_ff <= q_ff + 3'h1;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_B || !FRAME_ACTIVE) begin
      hi_ff <= 16'h0000;
    end else begin
      hi_ff <= hi_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  AST_WR_RESP: assert property (wr_go |-> ##2 BVALID)
    else $error("write response late");
  AST_FS_DIR: assert property (quiet |-> FSYNC_OE == (c2_ff[15] && !c2_ff[14]))
    else $error("sync drive wrong");
  AST_ENH_BUF: assert property (quiet |-> ENH_BUF_MODE == c2_ff[0])
    else $error("buffer mode wrong");
  AST_MASTER_CLK: assert property (quiet |-> SCLK_OE == c1_ff[5])
    else $error("clock drive wrong");
  AST_UNFRAMED: assert property (quiet && !c2_ff[15] |-> !FRAME_ACTIVE)
    else $error("frame while unframed");
  AST_FS_IDLE: assert property ($fell(FRAME_ACTIVE) && FSYNC_OE |-> FSYNC_OUT == !c2_ff[13])
    else $error("sync idle level wrong");
  AST_FS_EDGE: assert property ($rose(FRAME_ACTIVE) && FSYNC_OE |-> FSYNC_OUT == !(c2_ff[13] ^ c2_ff[1]))
    else $error("sync at first bit wrong");
  AST_FS_LEAD: assert property ($rose(FRAME_ACTIVE) && FSYNC_OE && !c2_ff[1] |-> $past(FSYNC_OUT) == c2_ff[13])
    else $error("lead sync missing");
  AST_FRAME_LEN: assert property ($fell(FRAME_ACTIVE) && SCLK_OE && c2_ff[15] && quiet |-> hi_ff == (per << 4))
    else $error("frame length wrong");
endmodule : scp_port_chk

bind scp_port_ctrl scp_port_chk u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .AWADDR(AWADDR),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .FSYNC_OUT(FSYNC_OUT), .FSYNC_OE(FSYNC_OE), .SCLK_OE(SCLK_OE),
  .FRAME_ACTIVE(FRAME_ACTIVE), .ENH_BUF_MODE(ENH_BUF_MODE));

// ---- scp_far_dev.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Far side frame sync source
// ------------------------------------------------------------
module scp_far_dev (
  input wire logic clk,
  input wire logic go,
  input wire logic pol,
  output logic fsync
);
  logic [2:0] cnt_ff = 3'h0;
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_ff <= 3'h4;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  // Idle at the inactive level so no stray edge opens a frame
  assign fsync = (cnt_ff != 3'h0) ? pol : !pol;
endmodule : scp_far_dev

// ---- scp_port_ctrl_tb.sv ----
`timescale 1ns/1ns
`include "scp_regs.svh"
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module testbench;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic FRAME_START = 1'b0, go = 1'b0, pol = 1'b1;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FSYNC_IN, FSYNC_OUT, FSYNC_OE;
  logic SCLK_OUT, SCLK_OE, FRAME_ACTIVE, ENH_BUF_MODE;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  int miscompares = 0;
  int tests_run = 0;
  always #4 CLOCK = !CLOCK;
  scp_port_ctrl DUT (.CLOCK(CLOCK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .FRAME_START(FRAME_START), .FSYNC_IN(FSYNC_IN), .FSYNC_OUT(FSYNC_OUT),
    .FSYNC_OE(FSYNC_OE), .SCLK_OUT(SCLK_OUT), .SCLK_OE(SCLK_OE),
    .FRAME_ACTIVE(FRAME_ACTIVE), .ENH_BUF_MODE(ENH_BUF_MODE));
  scp_far_dev FAR (.clk(CLOCK), .go(go), .pol(pol), .fsync(FSYNC_IN));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic hang;
    chk("handshake", 34'h0_0000_0001, 34'h0_0000_0000);
    end_of_test();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= {16'h0000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge CLOCK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) begin
        BREADY <= 1'b0;
        chk("write response", {32'h0000_0000, r}, {32'h0000_0000, BRESP});
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge CLOCK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) begin
        RREADY <= 1'b0;
        chk("read data", e, {RRESP, RDATA});
        return;
      end
    end
    hang();
  endtask : rd
  task automatic waitfa(input logic v, input int lim, input logic must, output int n,
                        output int r);
    logic prv;
    n = 0;
    r = 0;
    prv = SCLK_OUT;
    while (FRAME_ACTIVE !== v && n < lim) begin
      @(posedge CLOCK);
      n++;
      if (SCLK_OUT === 1'b1 && prv !== 1'b1) r++;
      prv = SCLK_OUT;
    end
    if (must && FRAME_ACTIVE !== v) hang();
  endtask : waitfa
  task automatic frame(input logic [15:0] c1, input logic [15:0] c2, input int len);
    int n;
    int r;
    wr(`SCP_CTRL1_ADDR, c1, `SCP_RESP_OKAY);
    wr(`SCP_CTRL2_ADDR, c2, `SCP_RESP_OKAY);
    FRAME_START <= 1'b1;
    @(posedge CLOCK);
    FRAME_START <= 1'b0;
    waitfa(1'b1, 600, 1'b1, n, r);
    chk("sync at first bit", {33'h0_0000_0000, !(c2[13] ^ c2[1])}, 34'(FSYNC_OUT));
    waitfa(1'b0, 9000, 1'b1, n, r);
    chk("frame length", 34'(len), 34'(n));
    chk("clock rises", 34'h0_0000_0010, 34'(r));
    chk("sync idle", {33'h0_0000_0000, !c2[13]}, 34'(FSYNC_OUT));
    chk("sync drive", 34'h0_0000_0001, 34'(FSYNC_OE));
  endtask : frame
  task automatic t_regs;
    rd(`SCP_CTRL1_ADDR, 34'h0_0000_0000);
    rd(`SCP_CTRL2_ADDR, 34'h0_0000_0000);
    wr(`SCP_CTRL2_ADDR, 16'hFFFF, `SCP_RESP_OKAY);
    rd(`SCP_CTRL2_ADDR, 34'h0_0000_E003);
    rd(8'h0C, {`SCP_RESP_SLVERR, 32'h0000_0000});
    wr(8'h10, 16'h1234, `SCP_RESP_SLVERR);
    wr(`SCP_CTRL2_ADDR, 16'h0000, `SCP_RESP_OKAY);
    $display("test regs done");
  endtask : t_regs
  task automatic t_div;
    logic [1:0] p [6] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
    logic [2:0] s [6] = '{3'h7, 3'h6, 3'h5, 3'h0, 3'h4, 3'h0};
    int k;
    for (int i = 0; i < 6; i++) begin
      k = (1 << (2 * (3 - p[i]))) * (8 - s[i]);
      frame({10'h000, 1'b1, s[i], p[i]}, 16'h8000, 16 * ((k == 1) ? 2 : k));
    end
    $display("test divide done");
  endtask : t_div
  task automatic t_sync;
    for (int j = 0; j < 4; j++) begin
      frame(16'h003B, {2'b10, j[1], 11'h000, j[0], 1'b0}, 32);
    end
    $display("test sync done");
  endtask : t_sync
  task automatic t_slave;
    int n;
    int r;
    wr(`SCP_CTRL1_ADDR, 16'h003F, `SCP_RESP_OKAY);
    wr(`SCP_CTRL2_ADDR, 16'hE000, `SCP_RESP_OKAY);
    FRAME_START <= 1'b1;
    @(posedge CLOCK);
    FRAME_START <= 1'b0;
    waitfa(1'b1, 20, 1'b0, n, r);
    chk("start in slave role", 34'h0_0000_0014, 34'(n));
    chk("sync drive", 34'h0_0000_0000, 34'(FSYNC_OE));
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    waitfa(1'b1, 30, 1'b1, n, r);
    waitfa(1'b0, 100, 1'b1, n, r);
    chk("slave frame length", 34'h0_0000_0020, 34'(n));
    chk("slave clock rises", 34'h0_0000_0010, 34'(r));
    wr(`SCP_CTRL2_ADDR, 16'h0001, `SCP_RESP_OKAY);
    rd(`SCP_CTRL2_ADDR, 34'h0_0000_0001);
    chk("buffer mode", 34'h0_0000_0001, 34'(ENH_BUF_MODE));
    wr(`SCP_CTRL2_ADDR, 16'h0000, `SCP_RESP_OKAY);
    rd(`SCP_CTRL2_ADDR, 34'h0_0000_0000);
    chk("buffer mode", 34'h0_0000_0000, 34'(ENH_BUF_MODE));
    $display("test slave done");
  endtask : t_slave
  initial begin
    repeat (3) @(posedge CLOCK);
    RST_B <= 1'b1;
    t_regs();
    t_div();
    t_sync();
    t_slave();
    end_of_test();
  end
endmodule : testbench
